/* mdu_pkg.sv */
/*
 * Constants, register map and carrier types of the multiply/divide unit.
 * Assumes a CPU special function register port with 4-bit data and
 * an 8-bit address, and one synchronous clock for everything.
 */
// Summary of operation
// - A multiply puts the unsigned product of C and E into D (high byte) and C (low byte) five machine cycles after start.
// - A divide puts the quotient of D:C by E into D:C and the remainder into F ten machine cycles after start.
// - Each operand and result register is a 4-bit read/write register and low/high pairs form the 8-bit C, D, E and F values.
// - Multiply and divide never change the E operand.
// - After a multiply the overflow flag is one exactly when the high product byte is nonzero.
// - Writing one to condition bit 0 while idle starts a multiply and that bit clears itself when the multiply completes.
// - Writing one to condition bit 1 while idle, with bit 0 zero, starts a divide and that bit clears itself when the divide completes ten machine cycles later.
// - After a divide the error flag is one exactly when the divisor E was zero.
// - A divide by zero loads D:C with all ones and copies the previous C value into F.
// - System reset clears all operand, result and condition bits to zero.
// - Nothing saves or restores the operand registers when an interrupt is taken.
package mdu_pkg;

    // ========================================================
    // register addresses
    localparam logic [7:0] MDU_ADDR_COND   = 8'h86;
    localparam logic [7:0] MDU_ADDR_C_LOW  = 8'h87;
    localparam logic [7:0] MDU_ADDR_C_HIGH = 8'h88;
    localparam logic [7:0] MDU_ADDR_D_LOW  = 8'h89;
    localparam logic [7:0] MDU_ADDR_D_HIGH = 8'h8a;
    localparam logic [7:0] MDU_ADDR_E_LOW  = 8'h8b;
    localparam logic [7:0] MDU_ADDR_E_HIGH = 8'h8c;
    localparam logic [7:0] MDU_ADDR_F_LOW  = 8'h8d;
    localparam logic [7:0] MDU_ADDR_F_HIGH = 8'h8e;

    // ========================================================
    // condition register fields and reset values
    localparam int         MDU_BIT_MULTIPLY_START_BIT     = 0;
    localparam int         MDU_BIT_DIVIDE_START_BIT     = 1;
    localparam int         MDU_BIT_EF       = 2;
    localparam int         MDU_BIT_OV       = 3;
    localparam logic [3:0] MDU_COND_RESET   = 4'h0;
    localparam logic [7:0] MDU_OPERAND_RESET = 8'h00;
    localparam logic [15:0] MDU_DIV_ZERO_QUOT = 16'hffff;

    // ========================================================
    // timing in machine cycles
    localparam int MDU_MUL_MCYCLES = 5;
    localparam int MDU_DIV_MCYCLES = 10;

    // ========================================================
    // types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [3:0] wdata;
    } mdu_sfr_req_t;

    typedef enum logic [1:0] {
        MDU_IDLE,
        MDU_MUL,
        MDU_DIV
    } mdu_state_t;

endpackage : mdu_pkg

/* mdu_mul_div.sv */
/*
 * Multiply/divide unit: nine 4-bit SFRs, an 8x8 multiplier and a
 * 16/8 divider that commit after a fixed count of machine cycles.
 * Assumes the CPU drives i_req synchronously to i_ref_clk, one
 * access per cycle, and that a machine cycle is CLKS_PER_MCYCLE clocks.
 */
`timescale 1ns/100ps
module mdu_mul_div #(
    parameter int unsigned CLKS_PER_MCYCLE = 4
) (
    // clock and reset
    input  wire logic                i_ref_clk,
    input  wire logic                i_rst,
    // sfr access
    input  wire mdu_pkg::mdu_sfr_req_t i_req,
    output logic [3:0]               o_rdata,
    output logic                     o_rvalid,
    // status
    output logic                     o_busy
);

    // ========================================================
    // storage
    logic [7:0]          opc;
    logic [7:0]          opd;
    logic [7:0]          ope;
    logic [7:0]          opf;
    logic                ov;
    logic                ef;
    logic                divide_start_bit;
    logic                multiply_start_bit;
    mdu_pkg::mdu_state_t state;
    logic [7:0]          clk_cnt;
    logic [3:0]          mcyc_cnt;
    logic [15:0]         lat_dividend;
    logic [7:0]          lat_e;
    logic [7:0]          lat_c;

    // ========================================================
    // decode and arithmetic
    logic        wr_cond;
    logic        start_mul;
    logic        start_div;
    logic        mcycle_tick;
    logic        commit;
    logic [15:0] product;
    logic [15:0] quotient;
    logic [7:0]  remainder;
    logic        div_zero;

    assign wr_cond   = i_req.wr && (i_req.addr == mdu_pkg::MDU_ADDR_COND);
    // a start write while busy is ignored; multiply wins if both bits are set
    assign start_mul = wr_cond && (state == mdu_pkg::MDU_IDLE)
                       && i_req.wdata[mdu_pkg::MDU_BIT_MULTIPLY_START_BIT];
    assign start_div = wr_cond && (state == mdu_pkg::MDU_IDLE)
                       && !i_req.wdata[mdu_pkg::MDU_BIT_MULTIPLY_START_BIT]
                       && i_req.wdata[mdu_pkg::MDU_BIT_DIVIDE_START_BIT];
    assign mcycle_tick = (state != mdu_pkg::MDU_IDLE)
                         && (clk_cnt == 8'(CLKS_PER_MCYCLE - 1));
    assign commit = mcycle_tick && (((state == mdu_pkg::MDU_MUL)
                        && (mcyc_cnt == 4'(mdu_pkg::MDU_MUL_MCYCLES - 1)))
                    || ((state == mdu_pkg::MDU_DIV)
                        && (mcyc_cnt == 4'(mdu_pkg::MDU_DIV_MCYCLES - 1))));
    // operands are latched at start so late sfr writes cannot corrupt a result
    // both factors widened to the product width so no bits are dropped
    assign product   = {8'h00, lat_dividend[7:0]} * {8'h00, lat_e};
    assign div_zero  = (lat_e == 8'h00);
    assign quotient  = div_zero ? mdu_pkg::MDU_DIV_ZERO_QUOT
                                : lat_dividend / {8'h00, lat_e};
    assign remainder = div_zero ? lat_c
                                : 8'(lat_dividend % {8'h00, lat_e});

    // ========================================================
    // sequencer: machine cycle divider restarts at each start so the
    // latency is an exact number of clocks
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state    <= mdu_pkg::MDU_IDLE;
            clk_cnt  <= 8'h00;
            mcyc_cnt <= 4'h0;
        end else begin
            unique case (state)
                mdu_pkg::MDU_IDLE: begin
                    clk_cnt  <= 8'h00;
                    mcyc_cnt <= 4'h0;
                    if (start_mul) begin
                        state <= mdu_pkg::MDU_MUL;
                    end else if (start_div) begin
                        state <= mdu_pkg::MDU_DIV;
                    end
                end
                mdu_pkg::MDU_MUL, mdu_pkg::MDU_DIV: begin
                    if (commit) begin
                        state <= mdu_pkg::MDU_IDLE;
                    end
                    if (mcycle_tick) begin
                        clk_cnt  <= 8'h00;
                        mcyc_cnt <= mcyc_cnt + 4'h1;
                    end else begin
                        clk_cnt  <= clk_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    // operand latch at start
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            lat_dividend <= {mdu_pkg::MDU_OPERAND_RESET, mdu_pkg::MDU_OPERAND_RESET};
            lat_e        <= mdu_pkg::MDU_OPERAND_RESET;
            lat_c        <= mdu_pkg::MDU_OPERAND_RESET;
        end else if (start_mul || start_div) begin
            lat_dividend <= start_mul ? {8'h00, opc} : {opd, opc};
            lat_e        <= ope;
            lat_c        <= opc;
        end
    end

    // ========================================================
    // operand registers: sfr writes, overridden by a commit in the same
    // cycle; no save/restore exists for interrupts
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            opc <= mdu_pkg::MDU_OPERAND_RESET;
            opd <= mdu_pkg::MDU_OPERAND_RESET;
            ope <= mdu_pkg::MDU_OPERAND_RESET;
            opf <= mdu_pkg::MDU_OPERAND_RESET;
        end else begin
            if (i_req.wr) begin
                unique case (i_req.addr)
                    mdu_pkg::MDU_ADDR_C_LOW:  opc[3:0] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_C_HIGH: opc[7:4] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_D_LOW:  opd[3:0] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_D_HIGH: opd[7:4] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_E_LOW:  ope[3:0] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_E_HIGH: ope[7:4] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_F_LOW:  opf[3:0] <= i_req.wdata;
                    mdu_pkg::MDU_ADDR_F_HIGH: opf[7:4] <= i_req.wdata;
                    default: ;
                endcase
            end
            // e is never a target of a commit
            if (commit && (state == mdu_pkg::MDU_MUL)) begin
                {opd, opc} <= product;
            end else if (commit) begin
                {opd, opc} <= quotient;
                opf        <= remainder;
            end
        end
    end

    // ========================================================
    // condition register: hardware updates win over a same-cycle write
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            {ov, ef, divide_start_bit, multiply_start_bit} <= mdu_pkg::MDU_COND_RESET;
        end else begin
            if (wr_cond) begin
                ov <= i_req.wdata[mdu_pkg::MDU_BIT_OV];
                ef <= i_req.wdata[mdu_pkg::MDU_BIT_EF];
            end
            if (start_mul) begin
                multiply_start_bit <= 1'b1;
            end else if (start_div) begin
                divide_start_bit <= 1'b1;
            end else if (commit && (state == mdu_pkg::MDU_MUL)) begin
                multiply_start_bit <= 1'b0;
                ov   <= (product[15:8] != 8'h00);
            end else if (commit) begin
                divide_start_bit <= 1'b0;
                ef   <= div_zero;
            end
        end
    end

    // ========================================================
    // read port: data and valid one clock after the read strobe
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata  <= 4'h0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            unique case (i_req.addr)
                mdu_pkg::MDU_ADDR_COND:   o_rdata <= {ov, ef, divide_start_bit, multiply_start_bit};
                mdu_pkg::MDU_ADDR_C_LOW:  o_rdata <= opc[3:0];
                mdu_pkg::MDU_ADDR_C_HIGH: o_rdata <= opc[7:4];
                mdu_pkg::MDU_ADDR_D_LOW:  o_rdata <= opd[3:0];
                mdu_pkg::MDU_ADDR_D_HIGH: o_rdata <= opd[7:4];
                mdu_pkg::MDU_ADDR_E_LOW:  o_rdata <= ope[3:0];
                mdu_pkg::MDU_ADDR_E_HIGH: o_rdata <= ope[7:4];
                mdu_pkg::MDU_ADDR_F_LOW:  o_rdata <= opf[3:0];
                mdu_pkg::MDU_ADDR_F_HIGH: o_rdata <= opf[7:4];
                default:                  o_rdata <= 4'h0;
            endcase
        end
    end

    // busy flag
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state == mdu_pkg::MDU_IDLE) ? (start_mul || start_div) : !commit;
        end
    end

    // ========================================================
    // checks
    localparam int MUL_LAT = mdu_pkg::MDU_MUL_MCYCLES * int'(CLKS_PER_MCYCLE);
    localparam int DIV_LAT = mdu_pkg::MDU_DIV_MCYCLES * int'(CLKS_PER_MCYCLE);
    localparam int MUL_CHK = MUL_LAT + 1;
    localparam int DIV_CHK = DIV_LAT + 1;
    localparam int MUL_RUN = MUL_LAT - 1;
    localparam int MUL_GAP = MUL_LAT - 2;

    property p_mul_result;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_mul |-> ##MUL_CHK {opd, opc} == ($past(opc, MUL_CHK) * $past(ope, MUL_CHK));
    endproperty
    a_mul_result: assert property (p_mul_result) else $error("multiply result wrong");

    property p_div_result;
        @(posedge i_ref_clk) disable iff (i_rst)
        (start_div && ope != 8'h00) |-> ##DIV_CHK ({opd, opc} == $past({opd, opc}, DIV_CHK)
            / {8'h00, $past(ope, DIV_CHK)}) && (opf == 8'($past({opd, opc}, DIV_CHK)
            % {8'h00, $past(ope, DIV_CHK)}));
    endproperty
    a_div_result: assert property (p_div_result) else $error("divide result wrong");

    property p_e_kept;
        @(posedge i_ref_clk) disable iff (i_rst)
        commit |=> $stable(ope);
    endproperty
    a_e_kept: assert property (p_e_kept) else $error("e changed by commit");

    property p_ov;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_mul |-> ##MUL_CHK ov == (opd != 8'h00);
    endproperty
    a_ov: assert property (p_ov) else $error("overflow flag wrong");

    property p_multiply_start_bit_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_mul |=> (multiply_start_bit throughout ##MUL_RUN 1'b1) ##1 !multiply_start_bit;
    endproperty
    a_multiply_start_bit_clear: assert property (p_multiply_start_bit_clear) else $error("mul start bit timing");

    property p_divide_start_bit_clear;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_div |-> ##DIV_LAT divide_start_bit ##1 !divide_start_bit;
    endproperty
    a_divide_start_bit_clear: assert property (p_divide_start_bit_clear) else $error("div start bit timing");

    property p_ef;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_div |-> ##DIV_CHK ef == ($past(ope, DIV_CHK) == 8'h00);
    endproperty
    a_ef: assert property (p_ef) else $error("error flag wrong");

    property p_div_zero;
        @(posedge i_ref_clk) disable iff (i_rst)
        (start_div && ope == 8'h00) |-> ##DIV_CHK ({opd, opc} == 16'hffff)
            && (opf == $past(opc, DIV_CHK));
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("divide by zero result wrong");

    property p_commit_tick;
        @(posedge i_ref_clk) disable iff (i_rst)
        start_mul |=> (!commit throughout ##MUL_GAP 1'b1) ##1 commit;
    endproperty
    a_commit_tick: assert property (p_commit_tick) else $error("commit at wrong cycle");

endmodule : mdu_mul_div

/* tb_top.sv */
/*
 * Self-checking bench for the multiply/divide unit: register reset values,
 * read/write access, a table of multiply and divide cases with latency, and
 * hand-written busy and mid-run reset cases.
 * Assumes mdu_pkg is compiled first and the unit runs one clock per
 * machine cycle, so results land 5 or 10 clocks after the start edge.
 */
`timescale 1ns/100ps
module tb_top;

    // ========================================================
    // bench signals
    typedef struct packed {
        logic        op;      // 0 multiply, 1 divide
        logic [7:0]  d;
        logic [7:0]  c;
        logic [7:0]  e;
        logic [7:0]  f;
        logic [15:0] dc_exp;
        logic [7:0]  f_exp;
        logic [3:0]  cond_exp;
    } mdu_row_t;

    logic                  i_ref_clk;
    logic                  i_rst;
    mdu_pkg::mdu_sfr_req_t req;
    logic [3:0]            o_rdata;
    logic                  o_rvalid;
    logic                  o_busy;
    int                    error_cnt;
    int                    samples_checked;
    int                    n;
    mdu_row_t              rows [7];

    // one clock per machine cycle keeps the run short
    mdu_mul_div #(.CLKS_PER_MCYCLE(1)) dut (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_req     (req),
        .o_rdata   (o_rdata),
        .o_rvalid  (o_rvalid),
        .o_busy    (o_busy)
    );

    // ========================================================
    // clock, 40 MHz
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    // ========================================================
    // shared tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // a gap edge before each access, so no strobe is set twice in a step
    task wr4(input logic [7:0] a, input logic [3:0] v);
        @(posedge i_ref_clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge i_ref_clk);
        #1 req.wr = 1'b0;
    endtask : wr4

    task rd4(input logic [7:0] a, output logic [3:0] v);
        @(posedge i_ref_clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
        @(posedge i_ref_clk);
        #1 req.rd = 1'b0;
        chk({15'h0000, o_rvalid}, 16'h0001);
        v = o_rdata;
    endtask : rd4

    task wr8(input logic [7:0] a, input logic [7:0] v);
        wr4(a, v[3:0]);
        wr4(a + 8'h01, v[7:4]);
    endtask : wr8

    task rd8(input logic [7:0] a, input logic [7:0] exp);
        logic [3:0] lo;
        logic [3:0] hi;
        rd4(a, lo);
        rd4(a + 8'h01, hi);
        chk({8'h00, hi, lo}, {8'h00, exp});
    endtask : rd8

    // count edges from the start edge until busy drops, bounded
    task wait_done(output int cnt);
        cnt = 0;
        while (o_busy === 1'b1 && cnt < 50) begin
            @(posedge i_ref_clk);
            #1 cnt++;
        end
    endtask : wait_done

    task conclude;
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // ========================================================
    // watchdog, far above the few hundred clocks the tests take
    initial begin
        #(25 * 20000);
        error_cnt++;
        conclude();
    end

    // ========================================================
    // main sequence
    initial begin
        logic [3:0] v;
        req = '0;
        error_cnt = 0;
        samples_checked = 0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        // every register reads zero after reset
        for (int a = 0; a < 9; a++) begin
            rd4(mdu_pkg::MDU_ADDR_COND + 8'(a), v);
            chk({12'h000, v}, 16'h0000);
        end
        // each operand nibble holds its own value; unmapped reads zero
        for (int a = 1; a < 9; a++) wr4(mdu_pkg::MDU_ADDR_COND + 8'(a), 4'(a + 6));
        for (int a = 1; a < 9; a++) begin
            rd4(mdu_pkg::MDU_ADDR_COND + 8'(a), v);
            chk({12'h000, v}, 16'(a + 6));
        end
        wr4(8'h8f, 4'h5);
        rd4(8'h8f, v);
        chk({12'h000, v}, 16'h0000);
        // ordinary cases: op, d, c, e, f, expected d:c, f, condition
        rows[0] = '{1'b0, 8'h77, 8'h12, 8'h34, 8'h5a, 16'h03a8, 8'h5a, 4'h8};
        rows[1] = '{1'b0, 8'h77, 8'h0f, 8'h0b, 8'h21, 16'h00a5, 8'h21, 4'h0};
        rows[2] = '{1'b0, 8'h00, 8'hff, 8'hff, 8'h00, 16'hfe01, 8'h00, 4'h8};
        rows[3] = '{1'b0, 8'h33, 8'h55, 8'h00, 8'h44, 16'h0000, 8'h44, 4'h0};
        rows[4] = '{1'b1, 8'h12, 8'h34, 8'h56, 8'hcc, 16'h0036, 8'h10, 4'h0};
        rows[5] = '{1'b1, 8'hff, 8'hff, 8'h01, 8'h77, 16'hffff, 8'h00, 4'h0};
        rows[6] = '{1'b1, 8'h12, 8'h9a, 8'h00, 8'h33, 16'hffff, 8'h9a, 4'h4};
        foreach (rows[i]) begin
            wr8(mdu_pkg::MDU_ADDR_D_LOW, rows[i].d);
            wr8(mdu_pkg::MDU_ADDR_C_LOW, rows[i].c);
            wr8(mdu_pkg::MDU_ADDR_E_LOW, rows[i].e);
            wr8(mdu_pkg::MDU_ADDR_F_LOW, rows[i].f);
            // writing only the start bit also clears both flags
            wr4(mdu_pkg::MDU_ADDR_COND, rows[i].op ? 4'h2 : 4'h1);
            wait_done(n);
            chk(16'(n), rows[i].op ? 16'(mdu_pkg::MDU_DIV_MCYCLES)
                                   : 16'(mdu_pkg::MDU_MUL_MCYCLES));
            rd8(mdu_pkg::MDU_ADDR_D_LOW, rows[i].dc_exp[15:8]);
            rd8(mdu_pkg::MDU_ADDR_C_LOW, rows[i].dc_exp[7:0]);
            rd8(mdu_pkg::MDU_ADDR_E_LOW, rows[i].e);
            rd8(mdu_pkg::MDU_ADDR_F_LOW, rows[i].f_exp);
            rd4(mdu_pkg::MDU_ADDR_COND, v);
            chk({12'h000, v}, {12'h000, rows[i].cond_exp});
        end
        // a multiply start and a C write during a divide change nothing
        wr8(mdu_pkg::MDU_ADDR_D_LOW, 8'h01);
        wr8(mdu_pkg::MDU_ADDR_C_LOW, 8'h00);
        wr8(mdu_pkg::MDU_ADDR_E_LOW, 8'h10);
        wr4(mdu_pkg::MDU_ADDR_COND, 4'h2);
        wr4(mdu_pkg::MDU_ADDR_COND, 4'h1);
        wr4(mdu_pkg::MDU_ADDR_C_LOW, 4'hf);
        wait_done(n);
        chk(16'(n < 50), 16'h0001);
        rd8(mdu_pkg::MDU_ADDR_C_LOW, 8'h10);
        rd8(mdu_pkg::MDU_ADDR_D_LOW, 8'h00);
        // remainder shows the divide used the latched C, not the late write
        rd8(mdu_pkg::MDU_ADDR_F_LOW, 8'h00);
        rd4(mdu_pkg::MDU_ADDR_COND, v);
        chk({12'h000, v}, 16'h0000);
        // both start bits at once: only the multiply runs, 0x10 times 0x10
        wr4(mdu_pkg::MDU_ADDR_COND, 4'h3);
        wait_done(n);
        chk(16'(n), 16'(mdu_pkg::MDU_MUL_MCYCLES));
        rd8(mdu_pkg::MDU_ADDR_D_LOW, 8'h01);
        rd8(mdu_pkg::MDU_ADDR_C_LOW, 8'h00);
        rd4(mdu_pkg::MDU_ADDR_COND, v);
        chk({12'h000, v}, 16'h0008);
        // reset in mid-multiply clears the run and the C, D, E and condition registers
        wr8(mdu_pkg::MDU_ADDR_C_LOW, 8'h0c);
        wr4(mdu_pkg::MDU_ADDR_COND, 4'h9);
        @(posedge i_ref_clk);
        #1 i_rst = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        chk({15'h0000, o_busy}, 16'h0000);
        rd8(mdu_pkg::MDU_ADDR_C_LOW, 8'h00);
        rd8(mdu_pkg::MDU_ADDR_E_LOW, 8'h00);
        rd4(mdu_pkg::MDU_ADDR_COND, v);
        chk({12'h000, v}, 16'h0000);
        repeat (12) @(posedge i_ref_clk);
        #1 rd8(mdu_pkg::MDU_ADDR_D_LOW, 8'h00);
        conclude();
    end

endmodule : tb_top
